/* File: core/pcs_pkg.sv */
// Constants for the configuration status word and revision identifier bank.
package pcs_pkg;

    // ************************************************************
    // Configuration space byte offsets
    // ************************************************************
    localparam logic [7:0] PCS_STATUS_OFS = 8'h06; // Byte offset of the status word.
    localparam logic [7:0] PCS_REVISION_OFS = 8'h08; // Byte offset of the revision byte.
    localparam logic [7:0] PCS_CAP_PTR_OFS = 8'h34; // Byte offset of the capabilities pointer.

    // ************************************************************
    // Status word field positions
    // ************************************************************
    localparam int PCS_DPE_BIT = 15; // Detected parity error.
    localparam int PCS_SSE_BIT = 14; // Signaled system error.
    localparam int PCS_RMA_BIT = 13; // Received master abort.
    localparam int PCS_RTA_BIT = 12; // Received target abort.
    localparam int PCS_STA_BIT = 11; // Signaled target abort.
    localparam int PCS_DST_HI_BIT = 10; // Upper bit of device select timing.
    localparam int PCS_DST_LO_BIT = 9; // Lower bit of device select timing.
    localparam int PCS_MASTER_DATA_PARITY_ERROR_BIT = 8; // Master data parity error.
    localparam int PCS_FBB_BIT = 7; // Fast back-to-back capable.
    localparam int PCS_HCC_BIT = 5; // High clock capable.
    localparam int PCS_CLP_BIT = 4; // Capability list present.
    localparam int PCS_PER_CMD_BIT = 6; // Parity error response bit in the command word.

    // ************************************************************
    // Event flag indices inside the sticky flag bank
    // ************************************************************
    localparam int PCS_NUM_FLAGS = 6; // Number of sticky event flags.
    localparam int PCS_F_MASTER_DATA_PARITY_ERROR = 0; // Flag index of master data parity error.
    localparam int PCS_F_STA = 1; // Flag index of signaled target abort.
    localparam int PCS_F_RTA = 2; // Flag index of received target abort.
    localparam int PCS_F_RMA = 3; // Flag index of received master abort.
    localparam int PCS_F_SSE = 4; // Flag index of signaled system error.
    localparam int PCS_F_DPE = 5; // Flag index of detected parity error.

    // ************************************************************
    // Device select timing encodings, fixed capability values, reset values and the default revision
    // ************************************************************
    typedef enum logic [1:0] {
        PCS_DEVSEL_FAST = 2'h0,
        PCS_DEVSEL_MEDIUM = 2'h1,
        PCS_DEVSEL_SLOW = 2'h2,
        PCS_DEVSEL_RSVD = 2'h3
    } pcs_devsel_e;

    localparam logic [1:0] PCS_DEVSEL_RESET = 2'h1; // Medium timing, the reset pattern.
    localparam logic PCS_FBB_VALUE = 1'h0; // No fast back-to-back to different agents.
    localparam logic PCS_HCC_VALUE = 1'h0; // Runs at 33 MHz only.
    localparam logic PCS_CLP_VALUE = 1'h1; // A capabilities list is present.
    localparam logic [5:0] PCS_FLAGS_RESET = 6'h00; // All event flags clear after reset.
    localparam logic [31:0] PCS_RDATA_RESET = 32'h0000_0000; // Read data after reset.
    localparam logic [7:0] PCS_REVISION_DEFAULT = 8'h5A; // Arbitrary neutral revision value.

endpackage

/* File: core/pcs_sticky_flags.sv */
// Bank of sticky event flags that only a reset clears.
`timescale 1ns/1ps

module pcs_sticky_flags #(
    parameter int N = 6 // Number of flags in the bank.
) (
    input wire logic ref_clk, // System clock.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire logic [N-1:0] set_req, // Set request per flag, any length.
    output logic [N-1:0] flag_q // Stored flag values.
);

    // ************************************************************
    // One flip-flop per flag
    // ************************************************************
    genvar gi;

    generate
        for (gi = 0; gi < N; gi++) begin : g_flag
            // Each flag latches on its first event and holds until reset.
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    flag_q[gi] <= 1'h0;
                end else if (set_req[gi]) begin
                    flag_q[gi] <= 1'h1;
                end
            end
        end
    endgenerate

endmodule

/* File: core/pcs_status_bank.sv */
// Configuration status word and revision identifier bank for a bus function.
`timescale 1ns/1ps

module pcs_status_bank
    import pcs_pkg::*;
#(
    parameter logic [7:0] REVISION = pcs_pkg::PCS_REVISION_DEFAULT, // Design revision, arbitrary default.
    parameter logic [1:0] DEVSEL_TIMING = pcs_pkg::PCS_DEVSEL_RESET // Medium select response code.
) (
    input wire logic ref_clk, // System clock, 50 MHz.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire logic cfg_rd, // Configuration read strobe, one cycle.
    input wire logic cfg_wr, // Configuration write strobe, one cycle.
    input wire logic [7:0] cfg_addr, // Configuration byte address; bits 1:0 are ignored by the decode.
    input wire logic [3:0] cfg_be, // Byte enables of the access.
    input wire logic [31:0] cfg_wdata, // Write data, discarded here.
    input wire logic parity_error_response, // Command word parity response enable.
    input wire logic bus_master_active, // The function is master of the current transaction.
    input wire logic parity_error_seen, // A bus parity error was detected.
    input wire logic serr_driven, // The function drives its system error line.
    input wire logic master_abort_end, // Own transaction ended in master abort.
    input wire logic special_cycle, // Current transaction is a special cycle.
    input wire logic target_abort_received, // Addressed target ended with target abort.
    input wire logic target_abort_signaled, // The function as target signalled target abort.
    input wire logic perr_driven_on_read, // The function drove parity error on a read.
    input wire logic perr_seen_on_write, // Parity error observed on a write.
    output logic [31:0] cfg_rdata, // Read data, registered.
    output logic cfg_rvalid // Read data valid, one cycle.
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [PCS_NUM_FLAGS-1:0] flag_set; // Qualified set requests for the flags.
    logic [PCS_NUM_FLAGS-1:0] flag_q; // Stored event flags.
    logic [15:0] status_word; // Assembled status word.
    logic [31:0] rdata_nxt; // Next read data.
    logic [7:0] status_dword_ofs; // Dword address holding the status word.
    logic [7:0] revision_dword_ofs; // Dword address holding the revision byte.
    logic [31:0] cfg_rdata_r; // Read data register.
    logic cfg_rvalid_r; // Read valid register.

    // Expands byte enables into a 32-bit lane mask.
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

    // ************************************************************
    // Event qualification
    // ************************************************************
    // Each event is reduced to a set request under its own conditions.
    always_comb begin
        flag_set = '0;
        flag_set[PCS_F_DPE] = parity_error_seen;
        flag_set[PCS_F_SSE] = serr_driven;
        flag_set[PCS_F_RMA] = bus_master_active & master_abort_end & ~special_cycle;
        flag_set[PCS_F_RTA] = bus_master_active & target_abort_received;
        flag_set[PCS_F_STA] = ~bus_master_active & target_abort_signaled;
        flag_set[PCS_F_MASTER_DATA_PARITY_ERROR] = (perr_driven_on_read | perr_seen_on_write) & bus_master_active
                               & parity_error_response;
    end

    // ************************************************************
    // Sticky flag storage
    // ************************************************************
    // The flags are set by events and cleared only by reset; writes never reach them.
    pcs_sticky_flags #(
        .N(PCS_NUM_FLAGS)
    ) u_flags (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .set_req(flag_set),
        .flag_q(flag_q)
    );

    // ************************************************************
    // Status word assembly
    // ************************************************************
    // Event flags, fixed capabilities and zero reserved bits form the word.
    always_comb begin
        status_word = 16'h0000;
        status_word[PCS_DPE_BIT] = flag_q[PCS_F_DPE];
        status_word[PCS_SSE_BIT] = flag_q[PCS_F_SSE];
        status_word[PCS_RMA_BIT] = flag_q[PCS_F_RMA];
        status_word[PCS_RTA_BIT] = flag_q[PCS_F_RTA];
        status_word[PCS_STA_BIT] = flag_q[PCS_F_STA];
        status_word[PCS_DST_HI_BIT:PCS_DST_LO_BIT] = DEVSEL_TIMING;
        status_word[PCS_MASTER_DATA_PARITY_ERROR_BIT] = flag_q[PCS_F_MASTER_DATA_PARITY_ERROR];
        status_word[PCS_FBB_BIT] = PCS_FBB_VALUE;
        status_word[PCS_HCC_BIT] = PCS_HCC_VALUE;
        status_word[PCS_CLP_BIT] = PCS_CLP_VALUE;
    end

    // ************************************************************
    // Read data selection
    // ************************************************************
    assign status_dword_ofs = {PCS_STATUS_OFS[7:2], 2'h0};
    assign revision_dword_ofs = {PCS_REVISION_OFS[7:2], 2'h0};

    // The status word fills the upper half of its dword, the revision the low byte of its dword.
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if ({cfg_addr[7:2], 2'h0} == status_dword_ofs) begin
            rdata_nxt = {16'h0000, 16'h0000} | ({16'h0000, status_word} << (PCS_STATUS_OFS[1:0] * 8));
        end else if ({cfg_addr[7:2], 2'h0} == revision_dword_ofs) begin
            rdata_nxt = {24'h00_0000, REVISION} << (PCS_REVISION_OFS[1:0] * 8);
        end
        rdata_nxt = rdata_nxt & lane_mask(cfg_be);
    end

    // ************************************************************
    // Read port registers
    // ************************************************************
    // Read data is captured at the edge that samples the strobe and shows one cycle later; writes are accepted and dropped.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cfg_rdata_r <= PCS_RDATA_RESET;
        end else if (cfg_rd) begin
            cfg_rdata_r <= rdata_nxt;
        end
    end

    // The valid pulse follows each read strobe by exactly one cycle.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cfg_rvalid_r <= 1'h0;
        end else begin
            cfg_rvalid_r <= cfg_rd;
        end
    end

    assign cfg_rdata = cfg_rdata_r;
    assign cfg_rvalid = cfg_rvalid_r;

    // ************************************************************
    // Assertions
    // ************************************************************
    // A detected parity error shows in the flag on the next cycle.
    AST_DPE_SET: assert property (@(posedge ref_clk) disable iff (sys_rst)
        parity_error_seen |=> flag_q[PCS_F_DPE])
        else $error("Parity error flag not set after detection.");

    // Driving system error sets its flag one cycle later.
    AST_SSE_SET: assert property (@(posedge ref_clk) disable iff (sys_rst)
        serr_driven |=> flag_q[PCS_F_SSE])
        else $error("System error flag not set.");

    // A special cycle master abort leaves a clear flag clear.
    AST_RMA_SPECIAL: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!flag_q[PCS_F_RMA] && master_abort_end && special_cycle && !(bus_master_active && master_abort_end
         && !special_cycle)) |=> !flag_q[PCS_F_RMA])
        else $error("Master abort flag set by a special cycle.");

    // A master abort on a normal owned transaction sets the flag.
    AST_RMA_SET: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (bus_master_active && master_abort_end && !special_cycle) |=> flag_q[PCS_F_RMA])
        else $error("Master abort flag not set.");

    // A received target abort while mastering sets its flag.
    AST_RTA_SET: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (bus_master_active && target_abort_received) |=> flag_q[PCS_F_RTA])
        else $error("Received target abort flag not set.");

    // A signalled target abort as target sets its flag.
    AST_STA_SET: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!bus_master_active && target_abort_signaled) |=> flag_q[PCS_F_STA])
        else $error("Signaled target abort flag not set.");

    // Without parity response the master parity flag cannot rise.
    AST_MASTER_DATA_PARITY_ERROR_GATE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!flag_q[PCS_F_MASTER_DATA_PARITY_ERROR] && !parity_error_response) |=> !flag_q[PCS_F_MASTER_DATA_PARITY_ERROR])
        else $error("Master parity flag set without parity response.");

    // With all three conditions the master parity flag rises.
    AST_MASTER_DATA_PARITY_ERROR_SET: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ((perr_driven_on_read || perr_seen_on_write) && bus_master_active && parity_error_response)
        |=> flag_q[PCS_F_MASTER_DATA_PARITY_ERROR])
        else $error("Master parity flag not set.");

    // Writes never change stored flags; only events may set them.
    AST_WRITE_IGNORED: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cfg_wr && flag_set == '0) |=> $stable(flag_q))
        else $error("Configuration write changed status flags.");

    // Once set, a flag stays set for the following cycles.
    AST_FLAGS_STICKY: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (flag_q != '0) |=> ((flag_q & $past(flag_q)) == $past(flag_q)))
        else $error("An event flag cleared without reset.");

    // A read of the status dword returns timing, capability and zero reserved bits.
    AST_STATUS_FIXED: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cfg_rd && cfg_addr == status_dword_ofs && cfg_be == 4'hF) |=> (cfg_rvalid
         && cfg_rdata[26:25] == DEVSEL_TIMING && cfg_rdata[23] == 1'h0 && cfg_rdata[22] == 1'h0
         && cfg_rdata[21] == 1'h0 && cfg_rdata[20] == 1'h1 && cfg_rdata[19:16] == 4'h0))
        else $error("Fixed status fields read wrong.");

    // A read of the revision dword returns the revision in the low byte.
    AST_REVISION_READ: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cfg_rd && cfg_addr == revision_dword_ofs && cfg_be[0]) |=> (cfg_rvalid
         && cfg_rdata[7:0] == REVISION))
        else $error("Revision byte read wrong.");

    // Flags are all clear on the cycle after reset.
    AST_RESET_CLEAR: assert property (@(posedge ref_clk)
        sys_rst |=> (flag_q == PCS_FLAGS_RESET && !cfg_rvalid))
        else $error("Flags not cleared by reset.");

    // Read valid mirrors the read strobe one cycle late, and only then.
    AST_RVALID_FOLLOWS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        1'h1 |=> (cfg_rvalid == $past(cfg_rd)))
        else $error("Read valid does not follow the read strobe.");

    // Without a read strobe the read data register keeps its value.
    AST_RDATA_HOLDS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !cfg_rd |=> $stable(cfg_rdata))
        else $error("Read data changed without a read.");

    // A write on its own never reaches the read data register.
    AST_WRITE_NO_DATA: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cfg_wr && !cfg_rd) |=> $stable(cfg_rdata))
        else $error("Configuration write reached the read data.");

    // Lanes whose byte enable was low read back as zero.
    AST_LANES_MASKED: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cfg_rd |=> ((cfg_rdata & ~lane_mask($past(cfg_be))) == 32'h0000_0000))
        else $error("A disabled byte lane returned data.");

    // The lower half of the status dword carries nothing from this bank.
    AST_STATUS_LOW_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cfg_rd && cfg_addr[7:2] == status_dword_ofs[7:2]) |=> (cfg_rdata[15:0] == 16'h0000))
        else $error("Status dword lower half not zero.");

    // A status read shows the flags as they stood at the strobe, in their own lanes.
    AST_STATUS_FLAGS_READ: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cfg_rd && cfg_addr[7:2] == status_dword_ofs[7:2] && cfg_be[3:2] == 2'h3) |=> (cfg_rdata[31:27]
         == $past({flag_q[PCS_F_DPE], flag_q[PCS_F_SSE], flag_q[PCS_F_RMA], flag_q[PCS_F_RTA], flag_q[PCS_F_STA]})
         && cfg_rdata[24] == $past(flag_q[PCS_F_MASTER_DATA_PARITY_ERROR])))
        else $error("Status read does not show the event flags.");

    // Above the revision byte its dword reads zero.
    AST_REVISION_UPPER_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cfg_rd && cfg_addr[7:2] == revision_dword_ofs[7:2]) |=> (cfg_rdata[31:8] == 24'h00_0000))
        else $error("Revision dword upper bytes not zero.");

    // Dwords outside the bank read as zero.
    AST_UNMAPPED_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cfg_rd && cfg_addr[7:2] != status_dword_ofs[7:2] && cfg_addr[7:2] != revision_dword_ofs[7:2])
        |=> (cfg_rdata == 32'h0000_0000))
        else $error("Unmapped dword returned data.");

    // Without mastership neither received abort flag can rise.
    AST_RECV_GATE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!flag_q[PCS_F_RTA] && !flag_q[PCS_F_RMA] && !bus_master_active)
        |=> (!flag_q[PCS_F_RTA] && !flag_q[PCS_F_RMA]))
        else $error("Received abort flag set while not master.");

    // Mastership keeps the signaled target abort flag from rising.
    AST_STA_GATE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!flag_q[PCS_F_STA] && bus_master_active) |=> !flag_q[PCS_F_STA])
        else $error("Signaled target abort flag set while master.");

    // The master parity flag cannot rise on a transfer it does not own.
    AST_MASTER_DATA_PARITY_ERROR_MASTER: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!flag_q[PCS_F_MASTER_DATA_PARITY_ERROR] && !bus_master_active) |=> !flag_q[PCS_F_MASTER_DATA_PARITY_ERROR])
        else $error("Master parity flag set while not master.");

    // The master parity flag needs a parity error on the owned transfer.
    AST_MASTER_DATA_PARITY_ERROR_CAUSE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!flag_q[PCS_F_MASTER_DATA_PARITY_ERROR] && !perr_driven_on_read && !perr_seen_on_write) |=> !flag_q[PCS_F_MASTER_DATA_PARITY_ERROR])
        else $error("Master parity flag set without a parity error.");

    // The detected parity flag rises only on a detected error.
    AST_DPE_CAUSE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!flag_q[PCS_F_DPE] && !parity_error_seen) |=> !flag_q[PCS_F_DPE])
        else $error("Parity error flag set without an error.");

    // The master abort flag rises only on a master abort.
    AST_RMA_CAUSE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!flag_q[PCS_F_RMA] && !master_abort_end) |=> !flag_q[PCS_F_RMA])
        else $error("Master abort flag set without an abort.");

endmodule

/* File: testbench/pcs_host_model.sv */
// Host bridge model that issues configuration reads and writes to the status bank.
`timescale 1ns/1ps

module pcs_host_model (
    input wire logic ref_clk, // System clock.
    input wire logic cfg_rvalid, // Read data valid from the bank.
    input wire logic [31:0] cfg_rdata, // Read data from the bank.
    output logic cfg_rd, // Read strobe.
    output logic cfg_wr, // Write strobe.
    output logic [7:0] cfg_addr, // Byte address.
    output logic [3:0] cfg_be, // Byte enables.
    output logic [31:0] cfg_wdata // Write data.
);
    // Idle bus at time zero.
    initial begin
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0000_0000;
    end

    // One-cycle read strobe; the address lines show the inverse afterwards so a stale value never matches.
    task automatic cfg_read(input logic [7:0] a, input logic [3:0] b, output logic [31:0] d);
        int n;
        d = 'x;
        n = 0;
        @(negedge ref_clk);
        cfg_rd = 1'b1;
        cfg_addr = a;
        cfg_be = b;
        @(negedge ref_clk);
        cfg_rd = 1'b0;
        cfg_addr = ~a;
        cfg_be = ~b;
        while (cfg_rvalid !== 1'b1 && n < 3) begin
            @(negedge ref_clk);
            n++;
        end
        if (cfg_rvalid === 1'b1) begin
            d = cfg_rdata;
        end
    endtask

    // One-cycle write strobe with released lines inverted afterwards.
    task automatic cfg_write(input logic [7:0] a, input logic [3:0] b, input logic [31:0] w);
        @(negedge ref_clk);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_be = b;
        cfg_wdata = w;
        @(negedge ref_clk);
        cfg_wr = 1'b0;
        cfg_addr = ~a;
        cfg_be = ~b;
        cfg_wdata = ~w;
    endtask
endmodule

/* File: testbench/tb.sv */
// Self-checking testbench for the configuration status and revision bank.
`timescale 1ns/1ps

module tb;
    import pcs_pkg::*;

    // ************************************************************
    // Signals and instances
    // ************************************************************
    localparam logic [7:0] REV_EXP = 8'h3C; // Arbitrary revision value for this run.
    logic ref_clk = 1'b0; // Bench clock.
    logic sys_rst = 1'b1; // Reset, held at start.
    logic [9:0] ev = 10'h000; // Event inputs: per, bm, pe, serr, ma, sc, tar, tas, pdr, psw.
    logic cfg_rd, cfg_wr, cfg_rvalid; // Configuration strobes and valid.
    logic [7:0] cfg_addr; // Address.
    logic [3:0] cfg_be; // Byte enables.
    logic [31:0] cfg_wdata, cfg_rdata; // Data lines.
    logic [31:0] rs = 32'h0000_005A; // Xorshift state, seeded with 90.
    logic [5:0] fl; // Expected sticky flags: dpe, sse, rma, rta, sta, master_data_parity_error.
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;

    pcs_host_model host (.ref_clk(ref_clk), .cfg_rvalid(cfg_rvalid), .cfg_rdata(cfg_rdata), .cfg_rd(cfg_rd),
        .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));

    pcs_status_bank #(.REVISION(REV_EXP)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .cfg_rd(cfg_rd),
        .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .parity_error_response(ev[9]), .bus_master_active(ev[8]), .parity_error_seen(ev[7]),
        .serr_driven(ev[6]), .master_abort_end(ev[5]), .special_cycle(ev[4]),
        .target_abort_received(ev[3]), .target_abort_signaled(ev[2]), .perr_driven_on_read(ev[1]),
        .perr_seen_on_write(ev[0]), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));

    // Clock generator, 20 ns period.
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    // ************************************************************
    // Expectation functions and shared tasks
    // ************************************************************
    // Xorshift generator seeded with 90.
    function logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    // Flags that one event vector sets, with each qualifier applied.
    function automatic logic [5:0] ev_flags(input logic [9:0] v);
        return {v[7], v[6], v[8] & v[5] & ~v[4], v[8] & v[3], ~v[8] & v[2], v[9] & v[8] & (v[1] | v[0])};
    endfunction

    // Whole status dword: status word in the upper half, fixed fields from the package.
    function automatic logic [31:0] status_dw(input logic [5:0] f);
        return {f[5:1], PCS_DEVSEL_RESET, f[0], PCS_FBB_VALUE, 1'b0, PCS_HCC_VALUE, PCS_CLP_VALUE, 4'h0, 16'h0000};
    endfunction

    // Compare one value and count it.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %08h expected %08h", $time, got, exp);
        end
    endtask

    // Read through the host model and compare with disabled lanes forced to zero.
    task automatic rd_chk(input logic [7:0] a, input logic [3:0] b, input logic [31:0] e);
        logic [31:0] d;
        host.cfg_read(a, b, d);
        check(d, e & {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}});
    endtask

    // Drive one event vector for one cycle and track the expected flags.
    task automatic ev_pulse(input logic [9:0] v);
        @(negedge ref_clk);
        ev = v;
        @(negedge ref_clk);
        ev = 10'h000;
        fl = fl | ev_flags(v);
    endtask

    // Synchronous reset for a number of cycles; flags are expected clear afterwards.
    task automatic do_reset(input int n);
        @(negedge ref_clk);
        sys_rst = 1'b1;
        repeat (n) @(negedge ref_clk);
        sys_rst = 1'b0;
        fl = 6'h00;
    endtask

    // Print counts and verdict, then stop.
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog on clock cycles.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            conclude();
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    logic [9:0] corner [10] = '{10'h080, 10'h040, 10'h130, 10'h120, 10'h008, 10'h108,
        10'h104, 10'h004, 10'h302, 10'h101};
    initial begin
        fl = 6'h00;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        // Reset values, dword decode and unmapped places.
        rd_chk(8'h04, 4'hF, status_dw(6'h00));
        rd_chk(8'h06, 4'hF, status_dw(6'h00));
        rd_chk(8'h08, 4'hF, {24'h000000, REV_EXP});
        rd_chk(8'h09, 4'hF, {24'h000000, REV_EXP});
        rd_chk(8'h0C, 4'hF, 32'h0000_0000);
        rd_chk(8'h00, 4'hF, 32'h0000_0000);
        $display("Test reset values done");
        // Writes to both registers leave them unchanged.
        host.cfg_write(8'h04, 4'hF, 32'hFFFF_FFFF);
        host.cfg_write(8'h08, 4'hF, 32'hFFFF_FFFF);
        rd_chk(8'h04, 4'hF, status_dw(6'h00));
        rd_chk(8'h08, 4'hF, {24'h000000, REV_EXP});
        $display("Test write ignored done");
        // dpe and sse once each, every qualified flag with its qualifier off and on, off first except for the master parity flag, checked cumulatively.
        for (int i = 0; i < 10; i++) begin
            ev_pulse(corner[i]);
            rd_chk(8'h04, 4'hC, status_dw(fl));
        end
        rd_chk(8'h04, 4'hF, status_dw(6'h3F));
        do_reset(2);
        rd_chk(8'h04, 4'hF, status_dw(6'h00));
        $display("Test corner events done");
        // Random events, random writes and random lanes, with resets now and then.
        for (int i = 0; i < 48; i++) begin
            if (i % 12 == 11) begin
                do_reset(1);
            end
            ev_pulse(10'(rnd() & rnd()));
            host.cfg_write(8'h04, 4'(rnd()), rnd());
            rd_chk(8'h04, 4'(rnd()), status_dw(fl));
        end
        rd_chk(8'h08, 4'h1, {24'h000000, REV_EXP});
        $display("Test random events done");
        conclude();
    end
endmodule
